/* File: hdl/tfw_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides and a synchronous flush.
`timescale 1ns/10ps
module tfw_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 16
) (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic flush_i,
   tfw_stream_if.snk wr,
   tfw_stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_N = (AW+1)'(DEPTH);

   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wptr_q;
   logic [AW-1:0] rptr_q;
   logic [AW:0]   cnt_q;
   logic          push;
   logic          pop;

   assign wr.ready = (cnt_q != DEPTH_N);
   assign rd.valid = (cnt_q != '0);
   assign rd.data  = mem_q[rptr_q];
   assign push     = wr.valid & wr.ready;
   assign pop      = rd.valid & rd.ready;

   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem_q[wptr_q] <= wr.data;
      end
   end

   // Wrap by comparison so DEPTH need not be a power of two
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i || flush_i)
      begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q  <= '0;
      end
      else
      begin
         if (push)
         begin
            wptr_q <= (wptr_q == AW'(DEPTH-1)) ? '0 : wptr_q + 1'b1;
         end
         if (pop)
         begin
            rptr_q <= (rptr_q == AW'(DEPTH-1)) ? '0 : rptr_q + 1'b1;
         end
         if (push && !pop)
         begin
            cnt_q <= cnt_q + 1'b1;
         end
         else if (pop && !push)
         begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule : tfw_fifo

/* File: hdl/tfw_pkg.sv */
// Constants and types shared by the track format writer.
// How it works
// - Each byte request from the formatter is answered by loading exactly one next format byte.
// - Single density opens with 40 FF, 6 00, one FC index mark and 26 FF.
// - Single density writes 26 sector fields of ID, CRC mark, gap, data mark, 128 data, CRC, gap.
// - After the last single density sector FF is supplied until the formatter interrupts.
// - Double density opens with 80 4E, 12 00, 3 F6, one FC index mark and 50 4E.
// - Double density writes 26 sector fields with F5 syncs, track, side, sector, size, 256 data.
// - After the last double density sector 4E is supplied until the formatter interrupts.
// - A custom layout uses one sector length of 128, 256, 512 or 1024 bytes.
// - The opening gap of a custom layout holds at least 16 filler bytes; the closing gap runs until the formatter interrupts.
// - The ID to data gap keeps its exact counts of filler, zero and sync bytes.
// - The gap between sectors has at least 10 FF and 4 00, or 16 4E, 8 00 and 3 syncs.
// - Values F5 through FE never appear in gaps, data or ID fields.
package tfw_pkg;

   // ----------------------------------------------------------------
   // Byte values
   // ----------------------------------------------------------------
   localparam logic [7:0] B_FF       = 8'hFF;
   localparam logic [7:0] B_00       = 8'h00;
   localparam logic [7:0] B_4E       = 8'h4E;
   localparam logic [7:0] B_IDX      = 8'hFC;
   localparam logic [7:0] B_IDAM     = 8'hFE;
   localparam logic [7:0] B_DAM      = 8'hFB;
   localparam logic [7:0] B_CRC      = 8'hF7;
   localparam logic [7:0] B_SYNC     = 8'hF5;
   localparam logic [7:0] B_IPRE     = 8'hF6;
   localparam logic [7:0] B_FILL_DEF = 8'hE5;
   localparam logic [7:0] B_CTL_LO   = 8'hF5;
   localparam logic [7:0] B_CTL_HI   = 8'hFE;

   // ----------------------------------------------------------------
   // Byte counts
   // ----------------------------------------------------------------
   localparam int CNT_W = 11;
   localparam logic [CNT_W-1:0] N_ONE       = 11'h001;
   localparam logic [CNT_W-1:0] N_BASE_LEN  = 11'h080;
   localparam logic [CNT_W-1:0] N_SD_GAP0   = 11'h028;
   localparam logic [CNT_W-1:0] N_SD_Z      = 11'h006;
   localparam logic [CNT_W-1:0] N_SD_GAP1   = 11'h01A;
   localparam logic [CNT_W-1:0] N_SD_GAP2   = 11'h00B;
   localparam logic [CNT_W-1:0] N_SD_GAP3   = 11'h01B;
   localparam logic [CNT_W-1:0] N_SD_MIN1   = 11'h010;
   localparam logic [CNT_W-1:0] N_SD_MIN3   = 11'h00A;
   localparam logic [CNT_W-1:0] N_DD_GAP0   = 11'h050;
   localparam logic [CNT_W-1:0] N_DD_Z      = 11'h00C;
   localparam logic [CNT_W-1:0] N_DD_SYNC   = 11'h003;
   localparam logic [CNT_W-1:0] N_DD_GAP1   = 11'h032;
   localparam logic [CNT_W-1:0] N_DD_GAP2   = 11'h016;
   localparam logic [CNT_W-1:0] N_DD_GAP3   = 11'h036;
   localparam logic [CNT_W-1:0] N_DD_MIN1   = 11'h010;
   localparam logic [CNT_W-1:0] N_DD_MIN3   = 11'h010;
   localparam logic [5:0]       N_SECT_STD  = 6'h1A;
   localparam logic [5:0]       SECT_FIRST  = 6'h01;
   localparam logic [1:0]       SIZE_SD_STD = 2'h0;
   localparam logic [1:0]       SIZE_DD_STD = 2'h1;

   // ----------------------------------------------------------------
   // Segment description
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      K_CONST = 3'h0,
      K_TRACK = 3'h1,
      K_SIDE  = 3'h2,
      K_SECT  = 3'h3,
      K_SIZE  = 3'h4,
      K_DATA  = 3'h5
   } tfw_kind_e;

   typedef struct packed {
      tfw_kind_e        kind;
      logic [7:0]       value;
      logic [CNT_W-1:0] count;
      logic             last;
   } tfw_seg_s;

endpackage : tfw_pkg

/* File: hdl/tfw_stream_if.sv */
// Valid/ready byte stream between the generator, the FIFO and the loader.
`timescale 1ns/10ps
interface tfw_stream_if #(
   parameter int W = 8
);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : tfw_stream_if

/* File: hdl/tfw_writer.sv */
// Host side track format writer: generates the layout and answers byte requests.
`timescale 1ns/10ps
module tfw_writer #(
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       start_i,
   input  wire logic       dd_i,
   input  wire logic       std_i,
   input  wire logic       omit_index_i,
   input  wire logic [1:0] size_code_i,
   input  wire logic [5:0] sect_count_i,
   input  wire logic [7:0] gap1_i,
   input  wire logic [7:0] gap3_i,
   input  wire logic [7:0] track_i,
   input  wire logic       side_i,
   input  wire logic [7:0] fill_i,
   input  wire logic       byte_request_i,
   input  wire logic       command_done_irq_i,
   output logic [7:0]      data_o,
   output logic            data_load_o,
   output logic            busy_o,
   output logic            done_o,
   output logic            start_err_o
);
   import tfw_pkg::*;

   // ----------------------------------------------------------------
   // Generator state
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_PRE  = 4'b0010,
      S_SECT = 4'b0100,
      S_TAIL = 4'b1000
   } tfw_state_e;

   tfw_state_e       state_q;
   logic [3:0]       idx_q;
   logic [CNT_W-1:0] cnt_q;
   logic [5:0]       sect_q;

   logic             dd_q;
   logic             omit_q;
   logic [1:0]       size_q;
   logic [5:0]       nsect_q;
   logic [CNT_W-1:0] gap1_q;
   logic [CNT_W-1:0] gap3_q;
   logic [7:0]       track_q;
   logic             side_q;
   logic [7:0]       fill_q;

   logic             wait_drop_q;
   logic             irq_seen_q;

   tfw_seg_s         cur;
   logic [7:0]       gen_byte;
   logic             gen_push;
   logic             seg_end;
   logic             start_ok;
   logic             abort;
   logic [CNT_W-1:0] gap1_lim;
   logic [CNT_W-1:0] gap3_lim;
   logic [CNT_W-1:0] gap1_in;
   logic [CNT_W-1:0] gap3_in;

   tfw_stream_if #(.W(8)) gen_s ();
   tfw_stream_if #(.W(8)) out_s ();

   function automatic logic is_ctl(input logic [7:0] b);
      is_ctl = (b >= B_CTL_LO) && (b <= B_CTL_HI);
   endfunction : is_ctl

   function automatic tfw_seg_s mk(input tfw_kind_e k, input logic [7:0] v,
                                   input logic [CNT_W-1:0] n, input logic l);
      tfw_seg_s s;
      s.kind  = k;
      s.value = v;
      s.count = n;
      s.last  = l;
      mk      = s;
   endfunction : mk

   // ----------------------------------------------------------------
   // Layout tables
   // ----------------------------------------------------------------
   // Track opening, with an omitted index mark written as one gap byte
   function automatic tfw_seg_s pre_seg(input logic dd, input logic omit,
                                        input logic [3:0] i, input logic [CNT_W-1:0] g1);
      tfw_seg_s s;
      logic [7:0] idx_b;
      idx_b = omit ? (dd ? B_4E : B_FF) : B_IDX;
      s = mk(K_CONST, B_00, N_ONE, 1'b1);
      if (!dd)
      begin
         unique case (i)
            4'h0: s = mk(K_CONST, B_FF, N_SD_GAP0, 1'b0);
            4'h1: s = mk(K_CONST, B_00, N_SD_Z, 1'b0);
            4'h2: s = mk(K_CONST, idx_b, N_ONE, 1'b0);
            default: s = mk(K_CONST, B_FF, g1, 1'b1);
         endcase
      end
      else
      begin
         unique case (i)
            4'h0: s = mk(K_CONST, B_4E, N_DD_GAP0, 1'b0);
            4'h1: s = mk(K_CONST, B_00, N_DD_Z, 1'b0);
            4'h2: s = mk(K_CONST, omit ? B_4E : B_IPRE, N_DD_SYNC, 1'b0);
            4'h3: s = mk(K_CONST, idx_b, N_ONE, 1'b0);
            default: s = mk(K_CONST, B_4E, g1, 1'b1);
         endcase
      end
      pre_seg = s;
   endfunction : pre_seg

   // One sector field; the data length is the base length shifted by the size code
   function automatic tfw_seg_s sect_seg(input logic dd, input logic [3:0] i,
                                         input logic [1:0] sz, input logic [CNT_W-1:0] g3);
      tfw_seg_s s;
      logic [CNT_W-1:0] dlen;
      dlen = N_BASE_LEN << sz;
      s = mk(K_CONST, B_00, N_ONE, 1'b1);
      if (!dd)
      begin
         unique case (i)
            4'h0: s = mk(K_CONST, B_00, N_SD_Z, 1'b0);
            4'h1: s = mk(K_CONST, B_IDAM, N_ONE, 1'b0);
            4'h2: s = mk(K_TRACK, B_00, N_ONE, 1'b0);
            4'h3: s = mk(K_CONST, B_00, N_ONE, 1'b0);
            4'h4: s = mk(K_SECT, B_00, N_ONE, 1'b0);
            4'h5: s = mk(K_SIZE, B_00, N_ONE, 1'b0);
            4'h6: s = mk(K_CONST, B_CRC, N_ONE, 1'b0);
            4'h7: s = mk(K_CONST, B_FF, N_SD_GAP2, 1'b0);
            4'h8: s = mk(K_CONST, B_00, N_SD_Z, 1'b0);
            4'h9: s = mk(K_CONST, B_DAM, N_ONE, 1'b0);
            4'hA: s = mk(K_DATA, B_00, dlen, 1'b0);
            4'hB: s = mk(K_CONST, B_CRC, N_ONE, 1'b0);
            default: s = mk(K_CONST, B_FF, g3, 1'b1);
         endcase
      end
      else
      begin
         unique case (i)
            4'h0: s = mk(K_CONST, B_00, N_DD_Z, 1'b0);
            4'h1: s = mk(K_CONST, B_SYNC, N_DD_SYNC, 1'b0);
            4'h2: s = mk(K_CONST, B_IDAM, N_ONE, 1'b0);
            4'h3: s = mk(K_TRACK, B_00, N_ONE, 1'b0);
            4'h4: s = mk(K_SIDE, B_00, N_ONE, 1'b0);
            4'h5: s = mk(K_SECT, B_00, N_ONE, 1'b0);
            4'h6: s = mk(K_SIZE, B_00, N_ONE, 1'b0);
            4'h7: s = mk(K_CONST, B_CRC, N_ONE, 1'b0);
            4'h8: s = mk(K_CONST, B_4E, N_DD_GAP2, 1'b0);
            4'h9: s = mk(K_CONST, B_00, N_DD_Z, 1'b0);
            4'hA: s = mk(K_CONST, B_SYNC, N_DD_SYNC, 1'b0);
            4'hB: s = mk(K_CONST, B_DAM, N_ONE, 1'b0);
            4'hC: s = mk(K_DATA, B_00, dlen, 1'b0);
            4'hD: s = mk(K_CONST, B_CRC, N_ONE, 1'b0);
            default: s = mk(K_CONST, B_4E, g3, 1'b1);
         endcase
      end
      sect_seg = s;
   endfunction : sect_seg

   // ----------------------------------------------------------------
   // Current segment and byte
   // ----------------------------------------------------------------
   always_comb
   begin
      unique case (state_q)
         S_PRE:   cur = pre_seg(dd_q, omit_q, idx_q, gap1_q);
         S_SECT:  cur = sect_seg(dd_q, idx_q, size_q, gap3_q);
         S_TAIL:  cur = mk(K_CONST, dd_q ? B_4E : B_FF, N_ONE, 1'b0);
         default: cur = mk(K_CONST, B_00, N_ONE, 1'b0);
      endcase
   end

   always_comb
   begin
      unique case (cur.kind)
         K_TRACK: gen_byte = track_q;
         K_SIDE:  gen_byte = {7'h00, side_q};
         K_SECT:  gen_byte = {2'h0, sect_q};
         K_SIZE:  gen_byte = {6'h00, size_q};
         K_DATA:  gen_byte = fill_q;
         default: gen_byte = cur.value;
      endcase
   end

   assign gen_s.valid = (state_q != S_IDLE) && !irq_seen_q;
   assign gen_s.data  = gen_byte;
   assign gen_push    = gen_s.valid && gen_s.ready;
   assign seg_end     = (cnt_q == cur.count - N_ONE);
   assign abort       = command_done_irq_i && (state_q != S_IDLE);

   // Custom gaps are clamped up to the legal minimum
   assign gap1_in  = {3'h0, gap1_i};
   assign gap3_in  = {3'h0, gap3_i};
   assign gap1_lim = dd_i ? N_DD_MIN1 : N_SD_MIN1;
   assign gap3_lim = dd_i ? N_DD_MIN3 : N_SD_MIN3;
   assign start_ok = start_i && (state_q == S_IDLE) && !is_ctl(track_i)
                     && (std_i || (sect_count_i != '0));

   // ----------------------------------------------------------------
   // Layout capture
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         dd_q    <= 1'b0;
         omit_q  <= 1'b0;
         size_q  <= SIZE_SD_STD;
         nsect_q <= N_SECT_STD;
         gap1_q  <= N_SD_GAP1;
         gap3_q  <= N_SD_GAP3;
         track_q <= B_00;
         side_q  <= 1'b0;
         fill_q  <= B_FILL_DEF;
      end
      else if (start_ok)
      begin
         dd_q    <= dd_i;
         track_q <= track_i;
         side_q  <= side_i;
         fill_q  <= is_ctl(fill_i) ? B_FILL_DEF : fill_i;
         if (std_i)
         begin
            omit_q  <= 1'b0;
            size_q  <= dd_i ? SIZE_DD_STD : SIZE_SD_STD;
            nsect_q <= N_SECT_STD;
            gap1_q  <= dd_i ? N_DD_GAP1 : N_SD_GAP1;
            gap3_q  <= dd_i ? N_DD_GAP3 : N_SD_GAP3;
         end
         else
         begin
            omit_q  <= omit_index_i;
            size_q  <= size_code_i;
            nsect_q <= sect_count_i;
            gap1_q  <= (gap1_in < gap1_lim) ? gap1_lim : gap1_in;
            gap3_q  <= (gap3_in < gap3_lim) ? gap3_lim : gap3_in;
         end
      end
   end

   // ----------------------------------------------------------------
   // Layout sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         state_q <= S_IDLE;
         idx_q   <= '0;
         cnt_q   <= '0;
         sect_q  <= SECT_FIRST;
      end
      else if (abort)
      begin
         state_q <= S_IDLE;
      end
      else if (start_ok)
      begin
         state_q <= S_PRE;
         idx_q   <= '0;
         cnt_q   <= '0;
         sect_q  <= SECT_FIRST;
      end
      else if (gen_push && state_q != S_TAIL)
      begin
         if (!seg_end)
         begin
            cnt_q <= cnt_q + N_ONE;
         end
         else
         begin
            cnt_q <= '0;
            idx_q <= idx_q + 4'h1;
            if (cur.last)
            begin
               idx_q <= '0;
               if (state_q == S_PRE)
               begin
                  state_q <= S_SECT;
               end
               else if (sect_q == nsect_q)
               begin
                  state_q <= S_TAIL;
               end
               else
               begin
                  sect_q <= sect_q + 6'h01;
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Request loader
   // ----------------------------------------------------------------
   // One load per request; the next request must show as a fresh rise
   assign out_s.ready = byte_request_i && !wait_drop_q && !data_load_o
                        && busy_o && !command_done_irq_i;

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         data_o      <= B_00;
         data_load_o <= 1'b0;
         wait_drop_q <= 1'b0;
      end
      else
      begin
         data_load_o <= out_s.valid && out_s.ready;
         if (out_s.valid && out_s.ready)
         begin
            data_o      <= out_s.data;
            wait_drop_q <= 1'b1;
         end
         else if (!byte_request_i)
         begin
            wait_drop_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         busy_o      <= 1'b0;
         done_o      <= 1'b0;
         start_err_o <= 1'b0;
         irq_seen_q  <= 1'b0;
      end
      else
      begin
         done_o      <= abort;
         start_err_o <= start_i && (state_q == S_IDLE) && !start_ok;
         irq_seen_q  <= abort;
         if (start_ok)
         begin
            busy_o <= 1'b1;
         end
         else if (abort)
         begin
            busy_o <= 1'b0;
         end
      end
   end

   tfw_fifo #(
      .W     (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .flush_i (abort || start_ok),
      .wr      (gen_s.snk),
      .rd      (out_s.src)
   );
endmodule : tfw_writer

/* File: tb/tfw_dev_model.sv */
// Behavioural formatter device: requests bytes, records them, ends by interrupt.
`timescale 1ns/10ps
module tfw_dev_model (
   input  wire logic        clk_i,
   input  wire logic        go_i,
   input  wire logic [15:0] len_i,
   input  wire logic [3:0]  gap_i,
   input  wire logic [7:0]  data_i,
   input  wire logic        load_i,
   output logic             byte_request_o,
   output logic             irq_o
);
   logic [7:0] mem [0:16383];
   logic       lost;
   int         cnt;
   int         crc_n;
   int         wt;

   initial
   begin
      byte_request_o = 1'b0;
      irq_o = 1'b0;
      forever
      begin
         wait (go_i === 1'b1);
         cnt = 0;
         crc_n = 0;
         lost = 1'b0;
         // One revolution is a fixed byte count; no mark is needed to end it
         while (cnt < int'(len_i))
         begin
            @(posedge clk_i);
            #1 byte_request_o = 1'b1;
            wt = 0;
            do
            begin
               @(posedge clk_i);
               #1 wt++;
            end while (load_i !== 1'b1 && wt < 64);
            mem[cnt] = (load_i === 1'b1) ? data_i : 8'h00;
            lost = lost | (load_i !== 1'b1);
            crc_n = crc_n + ((mem[cnt] === 8'hF7) ? 2 : 0);
            cnt++;
            if (gap_i != 4'h0) repeat (3) @(posedge clk_i);
            #1 byte_request_o = 1'b0;
            repeat (gap_i) @(posedge clk_i);
         end
         #1 irq_o = 1'b1;
         repeat (2) @(posedge clk_i);
         #1 irq_o = 1'b0;
         wait (go_i === 1'b0);
      end
   end
endmodule : tfw_dev_model

/* File: tb/tfw_writer_checker.sv */
// Port level assertions for the track format writer.
`timescale 1ns/10ps
module tfw_writer_checker (
   input wire logic       clk_i,
   input wire logic       rst_b_i,
   input wire logic       start_i,
   input wire logic       std_i,
   input wire logic [5:0] sect_count_i,
   input wire logic [7:0] track_i,
   input wire logic       byte_request_i,
   input wire logic       command_done_irq_i,
   input wire logic       data_load_o,
   input wire logic       busy_o,
   input wire logic       done_o,
   input wire logic       start_err_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   logic ctl_trk;
   logic bad_start;
   assign ctl_trk   = (track_i >= 8'hF5) && (track_i <= 8'hFE);
   assign bad_start = ctl_trk || (!std_i && (sect_count_i == 6'h00));

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   property p_load_pulse;
      data_load_o |=> !data_load_o;
   endproperty
   a_load_pulse: assert property (p_load_pulse)
      else $error("load strobe longer than one cycle");
   property p_load_cause;
      data_load_o |-> $past(byte_request_i) && $past(busy_o) && !$past(command_done_irq_i);
   endproperty
   a_load_cause: assert property (p_load_cause)
      else $error("load without a request while busy");
   sequence s_held_req;
      data_load_o ##1 byte_request_i ##1 byte_request_i;
   endsequence
   property p_one_per_rise;
      s_held_req |=> !data_load_o;
   endproperty
   a_one_per_rise: assert property (p_one_per_rise)
      else $error("second load on a held request");
   property p_busy_hold;
      busy_o && !command_done_irq_i |=> busy_o;
   endproperty
   a_busy_hold: assert property (p_busy_hold)
      else $error("busy dropped before the interrupt");
   property p_done;
      busy_o && command_done_irq_i |=> done_o && !busy_o;
   endproperty
   a_done: assert property (p_done)
      else $error("interrupt did not end the format");
   property p_done_cause;
      $rose(done_o) |-> $past(busy_o) && $past(command_done_irq_i);
   endproperty
   a_done_cause: assert property (p_done_cause)
      else $error("done without an interrupt while busy");
   property p_start_ok;
      !busy_o && start_i && !bad_start |=> busy_o && !start_err_o;
   endproperty
   a_start_ok: assert property (p_start_ok)
      else $error("valid start not taken");
   property p_refuse;
      !busy_o && start_i && bad_start |=> start_err_o && !busy_o ##1 !start_err_o;
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("bad start not refused by a single pulse");
   property p_err_cause;
      start_err_o |-> !$past(busy_o) && $past(start_i);
   endproperty
   a_err_cause: assert property (p_err_cause)
      else $error("refusal without a start");

   c_load:  cover property (data_load_o);
   c_done:  cover property (done_o);
   c_error: cover property (start_err_o);
endmodule : tfw_writer_checker

bind tfw_writer tfw_writer_checker tfw_writer_checker_i (
   .clk_i              (clk_i),
   .rst_b_i            (rst_b_i),
   .start_i            (start_i),
   .std_i              (std_i),
   .sect_count_i       (sect_count_i),
   .track_i            (track_i),
   .byte_request_i     (byte_request_i),
   .command_done_irq_i (command_done_irq_i),
   .data_load_o        (data_load_o),
   .busy_o             (busy_o),
   .done_o             (done_o),
   .start_err_o        (start_err_o)
);

/* File: tb/track_format_writer_bench.sv */
// Self-checking testbench of the track format writer against a device model.
`timescale 1ns/10ps
module track_format_writer_bench;
   import tfw_pkg::*;

   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        start = 1'b0;
   logic        dd = 1'b0;
   logic        std = 1'b1;
   logic        omit = 1'b0;
   logic [1:0]  size_code = 2'h0;
   logic [5:0]  sect = 6'h1A;
   logic [7:0]  gap1 = 8'h10;
   logic [7:0]  gap3 = 8'h10;
   logic [7:0]  trk = 8'h00;
   logic        side = 1'b0;
   logic [7:0]  fill = 8'hE5;
   logic        go = 1'b0;
   logic [15:0] len = 16'h0000;
   logic [3:0]  gapm = 4'h0;
   logic        req;
   logic        irq;
   logic [7:0]  data;
   logic        load;
   logic        busy;
   logic        done;
   logic        start_err;
   int          error_cnt = 0;
   int          n_compared = 0;
   int          pos = 0;

   always #12.5 clk = ~clk;

   tfw_writer tfw_writer_i (.clk_i(clk), .rst_b_i(rst_b), .start_i(start), .dd_i(dd),
      .std_i(std), .omit_index_i(omit), .size_code_i(size_code), .sect_count_i(sect),
      .gap1_i(gap1), .gap3_i(gap3), .track_i(trk), .side_i(side), .fill_i(fill),
      .byte_request_i(req), .command_done_irq_i(irq), .data_o(data), .data_load_o(load),
      .busy_o(busy), .done_o(done), .start_err_o(start_err));

   tfw_dev_model tfw_dev_model_i (.clk_i(clk), .go_i(go), .len_i(len), .gap_i(gapm),
      .data_i(data), .load_i(load), .byte_request_o(req), .irq_o(irq));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task print_verdict;
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : print_verdict

   task cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_byte

   task cmp_bit(input logic got, input logic exp);
      cmp_byte({7'h00, got}, {7'h00, exp});
   endtask : cmp_bit

   // Compares the next n recorded bytes against one value
   task seg(input int n, input logic [7:0] v);
      repeat (n)
      begin
         cmp_byte(tfw_dev_model_i.mem[pos], v);
         pos++;
      end
   endtask : seg

   task pulse_start;
      @(posedge clk);
      #1 start = 1'b1;
      @(posedge clk);
      #1 start = 1'b0;
   endtask : pulse_start

   task run_fmt;
      pos = 0;
      pulse_start();
      cmp_bit(busy, 1'b1);
      go = 1'b1;
      // Bounded wait; a full double density track takes about 20800 cycles
      for (int k = 0; k < 40000 && done !== 1'b1; k++)
      begin
         @(posedge clk);
         #1;
      end
      cmp_bit(done, 1'b1);
      cmp_bit(busy, 1'b0);
      cmp_bit(tfw_dev_model_i.lost, 1'b0);
      go = 1'b0;
   endtask : run_fmt

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task test_sd_std;
      dd = 1'b0;
      std = 1'b1;
      trk = 8'h05;
      len = 16'd5200;
      run_fmt();
      cmp_byte(8'(tfw_dev_model_i.crc_n), 8'h68);
      seg(40, B_FF);
      seg(6, B_00);
      seg(1, B_IDX);
      seg(26, B_FF);
      for (int s = 1; s <= 26; s++)
      begin
         seg(6, B_00);
         seg(1, B_IDAM);
         seg(1, trk);
         seg(1, B_00);
         seg(1, 8'(s));
         seg(1, B_00);
         seg(1, B_CRC);
         seg(11, B_FF);
         seg(6, B_00);
         seg(1, B_DAM);
         seg(128, fill);
         seg(1, B_CRC);
         seg(27, B_FF);
      end
      seg(5200 - pos, B_FF);
   endtask : test_sd_std

   task test_dd_std;
      dd = 1'b1;
      trk = 8'h4C;
      side = 1'b1;
      fill = 8'h6D;
      len = 16'd10400;
      run_fmt();
      seg(80, B_4E);
      seg(12, B_00);
      seg(3, B_IPRE);
      seg(1, B_IDX);
      seg(50, B_4E);
      for (int s = 1; s <= 26; s++)
      begin
         seg(12, B_00);
         seg(3, B_SYNC);
         seg(1, B_IDAM);
         seg(1, trk);
         seg(1, 8'h01);
         seg(1, 8'(s));
         seg(1, 8'h01);
         seg(1, B_CRC);
         seg(22, B_4E);
         seg(12, B_00);
         seg(3, B_SYNC);
         seg(1, B_DAM);
         seg(256, fill);
         seg(1, B_CRC);
         seg(54, B_4E);
      end
      seg(10400 - pos, B_4E);
   endtask : test_dd_std

   task test_custom;
      dd = 1'b0;
      std = 1'b0;
      omit = 1'b1;
      sect = 6'h01;
      gap1 = 8'h05;
      gap3 = 8'h03;
      trk = 8'h03;
      fill = 8'hF6;
      len = 16'd300;
      gapm = 4'h5;
      run_fmt();
      seg(40, B_FF);
      seg(6, B_00);
      seg(1, B_FF);
      seg(16, B_FF);
      seg(6, B_00);
      seg(1, B_IDAM);
      seg(1, trk);
      seg(1, B_00);
      seg(1, 8'h01);
      seg(1, B_00);
      seg(1, B_CRC);
      seg(11, B_FF);
      seg(6, B_00);
      seg(1, B_DAM);
      seg(128, B_FILL_DEF);
      seg(1, B_CRC);
      seg(10, B_FF);
      seg(300 - pos, B_FF);
   endtask : test_custom

   task test_refuse;
      std = 1'b1;
      trk = 8'hF5;
      pulse_start();
      cmp_bit(start_err, 1'b1);
      cmp_bit(busy, 1'b0);
      std = 1'b0;
      trk = 8'h02;
      sect = 6'h00;
      pulse_start();
      cmp_bit(start_err, 1'b1);
      cmp_bit(busy, 1'b0);
   endtask : test_refuse

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial
   begin
      repeat (5) @(posedge clk);
      #1 rst_b = 1'b1;
      cmp_byte(data, 8'h00);
      cmp_bit(busy, 1'b0);
      test_sd_std();
      test_dd_std();
      test_custom();
      test_refuse();
      print_verdict();
   end

   initial
   begin
      #2000000;
      error_cnt++;
      print_verdict();
   end
endmodule : track_format_writer_bench
